// ==== rtl/branch_target_regs.svh ====
`ifndef BRANCH_TARGET_REGS_SVH
`define BRANCH_TARGET_REGS_SVH
// Instruction step sizes
`define STEP_WIDE 32'h0000_0004
`define STEP_NARROW 32'h0000_0002
// Condition-register bit numbering offset
`define CR_BIT_BASE 32
// Branch-options field bit positions
`define OPT_COND_IGNORE 0
`define OPT_COND_SENSE 1
`define OPT_CTR_IGNORE 2
`define OPT_CTR_SENSE 3
// Compact options field bit positions
`define LOPT_CTR_USE 0
`define LOPT_SENSE 1
// Reset values
`define RESET_ADDRESS 32'h0000_0000
`define RESET_COUNT 32'h0000_0000
`define RESET_LINK 32'h0000_0000
`define RESET_COND 32'h0000_0000
`endif

// ==== rtl/branch_target_pkg.sv ====
package branch_target_pkg;
  typedef enum logic [5:0] {
    JUMP_NONE = 6'b000001,
    JUMP_LONG_UNCOND = 6'b000010,
    JUMP_LONG_RELATIVE = 6'b000100,
    JUMP_SHORT_RELATIVE = 6'b001000,
    JUMP_LONG_COND = 6'b010000,
    JUMP_VIA_COUNT = 6'b100000
  } jump_kind_t;
  typedef enum logic [1:0] {
    COND_COMPACT = 2'b01,
    COND_SHORT = 2'b10
  } cond_form_t;
endpackage

// ==== rtl/cond_select_if.sv ====
interface cond_select_if;
  logic [31:0] condition_register;
  logic [4:0] bit_index;
  logic bit_value;
  modport user (output condition_register, output bit_index, input bit_value);
  modport sel (input condition_register, input bit_index, output bit_value);
endinterface

// ==== rtl/cond_bit_select.sv ====
// Picks condition-register bit (index + 32), big-endian numbering
module cond_bit_select (
  cond_select_if.sel port
);
  // Architectural bit 32 is the msb of the 32-bit register
  always_comb begin
    port.bit_value = port.condition_register[5'd31 - port.bit_index];
  end
endmodule

// ==== rtl/branch_target_unit.sv ====
`include "branch_target_regs.svh"
module branch_target_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire branch_target_pkg::jump_kind_t i_kind,
  input wire logic i_compact_valid,
  input wire branch_target_pkg::cond_form_t i_compact_form,
  input wire logic [31:0] i_current_instr_address,
  input wire logic i_absolute_flag,
  input wire logic i_link_flag,
  input wire logic [23:0] i_long_jump_offset,
  input wire logic [23:0] i_long_displacement,
  input wire logic [7:0] i_short_displacement,
  input wire logic [13:0] i_cond_displacement,
  input wire logic [14:0] i_mid_displacement,
  input wire logic [4:0] i_branch_options,
  input wire logic [4:0] i_condition_index,
  input wire logic [3:0] i_long_options_field,
  input wire logic [3:0] i_long_condition_index,
  input wire logic i_short_options_bit,
  input wire logic [1:0] i_short_condition_index,
  input wire logic i_cr_write,
  input wire logic [31:0] i_condition_register,
  input wire logic i_count_write,
  input wire logic [31:0] i_count_value,
  output logic o_next_valid,
  output logic [31:0] o_next_instr_address,
  output logic o_taken,
  output logic [31:0] o_link_register,
  output logic [31:0] o_count_register,
  output logic [31:0] o_condition_register
);
  import branch_target_pkg::*;

  // ------------------------------------------------------------
  // Architectural state and datapath signals
  // ------------------------------------------------------------
  logic [31:0] current_instr_address;
  logic [31:0] seq_wide;
  logic [31:0] seq_narrow;
  logic [31:0] next_target;
  logic [31:0] next_address;
  logic next_taken;
  logic next_link_write;
  logic [31:0] next_link;
  logic next_decrement;
  logic [31:0] count_dec;
  logic ctr_ok;
  logic cond_ok;
  logic [4:0] sel_index;
  logic is_cond_form;
  cond_select_if cr_sel ();

  assign current_instr_address = i_current_instr_address;
  // Carries out of bit 31 drop by the 32-bit sum widths
  assign seq_wide = current_instr_address + `STEP_WIDE;
  assign seq_narrow = current_instr_address + `STEP_NARROW;
  assign count_dec = o_count_register - 32'h0000_0001;

  // ------------------------------------------------------------
  // Condition-bit selection
  // ------------------------------------------------------------
  // Narrow index fields zero-extend, limiting reach per form
  always_comb begin
    sel_index = i_condition_index;
    if (i_compact_valid && i_compact_form == COND_COMPACT) begin
      sel_index = {1'b0, i_long_condition_index};
    end else if (i_compact_valid && i_compact_form == COND_SHORT) begin
      sel_index = {3'b000, i_short_condition_index};
    end
  end

  // Bit meaning per field is set by the writers; this unit only reads them
  assign cr_sel.condition_register = o_condition_register;
  assign cr_sel.bit_index = sel_index;

  cond_bit_select u_sel (
    .port(cr_sel.sel)
  );

  // ------------------------------------------------------------
  // Counter and condition tests
  // ------------------------------------------------------------
  // Tests use the already decremented count
  always_comb begin
    ctr_ok = 1'b1;
    cond_ok = 1'b1;
    next_decrement = 1'b0;
    is_cond_form = 1'b0;
    if (i_compact_valid && i_compact_form == COND_COMPACT) begin
      is_cond_form = 1'b1;
      next_decrement = i_long_options_field[`LOPT_CTR_USE];
      ctr_ok = !i_long_options_field[`LOPT_CTR_USE] ||
               ((count_dec != 32'h0000_0000) ^ i_long_options_field[`LOPT_SENSE]);
      cond_ok = i_long_options_field[`LOPT_CTR_USE] ||
                (cr_sel.bit_value == i_long_options_field[`LOPT_SENSE]);
    end else if (i_compact_valid && i_compact_form == COND_SHORT) begin
      is_cond_form = 1'b1;
      cond_ok = (cr_sel.bit_value == i_short_options_bit);
    end else if (i_kind == JUMP_LONG_COND) begin
      is_cond_form = 1'b1;
      next_decrement = !i_branch_options[`OPT_CTR_IGNORE];
      ctr_ok = i_branch_options[`OPT_CTR_IGNORE] ||
               ((count_dec != 32'h0000_0000) ^ i_branch_options[`OPT_CTR_SENSE]);
      cond_ok = i_branch_options[`OPT_COND_IGNORE] ||
                (cr_sel.bit_value == i_branch_options[`OPT_COND_SENSE]);
    end else if (i_kind == JUMP_VIA_COUNT) begin
      is_cond_form = 1'b1;
      cond_ok = i_branch_options[`OPT_COND_IGNORE] ||
                (cr_sel.bit_value == i_branch_options[`OPT_COND_SENSE]);
    end
  end

  // ------------------------------------------------------------
  // Target and link computation
  // ------------------------------------------------------------
  always_comb begin
    next_target = seq_wide;
    next_link = seq_wide;
    next_link_write = i_link_flag;
    if (i_compact_valid && i_compact_form == COND_COMPACT) begin
      next_target = current_instr_address + {{16{i_mid_displacement[14]}}, i_mid_displacement, 1'b0};
    end else if (i_compact_valid && i_compact_form == COND_SHORT) begin
      next_target = current_instr_address + {{23{i_short_displacement[7]}}, i_short_displacement, 1'b0};
      next_link_write = 1'b0;
    end else begin
      case (i_kind)
        JUMP_LONG_UNCOND: begin
          next_target = (i_absolute_flag ? 32'h0000_0000 : current_instr_address) +
                        {{6{i_long_jump_offset[23]}}, i_long_jump_offset, 2'b00};
        end
        JUMP_LONG_RELATIVE: begin
          next_target = current_instr_address + {{7{i_long_displacement[23]}}, i_long_displacement, 1'b0};
        end
        JUMP_SHORT_RELATIVE: begin
          next_target = current_instr_address + {{23{i_short_displacement[7]}}, i_short_displacement, 1'b0};
          next_link = seq_narrow;
        end
        JUMP_LONG_COND: begin
          next_target = (i_absolute_flag ? 32'h0000_0000 : current_instr_address) +
                        {{16{i_cond_displacement[13]}}, i_cond_displacement, 2'b00};
        end
        JUMP_VIA_COUNT: begin
          next_target = {o_count_register[31:2], 2'b00};
        end
        default: begin
          next_target = seq_wide;
          next_link_write = 1'b0;
        end
      endcase
    end
  end

  // Untaken conditionals fall through by their own size
  always_comb begin
    next_taken = ctr_ok && cond_ok;
    if (!is_cond_form) begin
      next_taken = !(i_kind == JUMP_NONE) || i_compact_valid;
    end
    if (next_taken) begin
      next_address = next_target;
    end else if (i_compact_valid && i_compact_form == COND_SHORT) begin
      next_address = seq_narrow;
    end else begin
      next_address = seq_wide;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Next address pulses one cycle after the request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_next_valid <= 1'b0;
      o_next_instr_address <= `RESET_ADDRESS;
      o_taken <= 1'b0;
    end else begin
      o_next_valid <= i_valid;
      if (i_valid) begin
        o_next_instr_address <= next_address;
        o_taken <= next_taken;
      end
    end
  end

  // Link written on any branch request with the flag set, taken or not; never by a short conditional
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_link_register <= `RESET_LINK;
    end else if (i_valid && next_link_write) begin
      o_link_register <= next_link;
    end
  end

  // Branch decrement wins over a pipeline count load in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_count_register <= `RESET_COUNT;
    end else if (i_valid && next_decrement) begin
      o_count_register <= count_dec;
    end else if (i_count_write) begin
      o_count_register <= i_count_value;
    end
  end

  // Condition register is loaded by completing instructions
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_condition_register <= `RESET_COND;
    end else if (i_cr_write) begin
      o_condition_register <= i_condition_register;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_link_plus4;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_link_flag && !i_compact_valid &&
     (i_kind == JUMP_LONG_UNCOND || i_kind == JUMP_LONG_COND)) |=> (o_link_register == $past(seq_wide));
  endproperty
  a_link_plus4: assert property (p_link_plus4) else $error("link not address plus 4");

  property p_short_link;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_link_flag && !i_compact_valid && i_kind == JUMP_SHORT_RELATIVE)
      |=> (o_link_register == $past(current_instr_address) + 32'h0000_0002);
  endproperty
  a_short_link: assert property (p_short_link) else $error("short link not address plus 2");

  property p_decrement;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && !i_compact_valid && i_kind == JUMP_LONG_COND && !i_branch_options[2])
      |=> (o_count_register == $past(o_count_register) - 32'h0000_0001);
  endproperty
  a_decrement: assert property (p_decrement) else $error("count not decremented");

  property p_count_jump_no_dec;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && !i_compact_valid && i_kind == JUMP_VIA_COUNT && !i_count_write)
      |=> $stable(o_count_register);
  endproperty
  a_count_jump_no_dec: assert property (p_count_jump_no_dec) else $error("count jump changed count");

  property p_short_cond_fall;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_compact_valid && i_compact_form == COND_SHORT && !next_taken)
      |=> (o_next_instr_address == $past(current_instr_address) + 32'h0000_0002);
  endproperty
  a_short_cond_fall: assert property (p_short_cond_fall) else $error("short fall-through wrong");

  property p_short_no_link;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_compact_valid && i_compact_form == COND_SHORT) |=> $stable(o_link_register);
  endproperty
  a_short_no_link: assert property (p_short_no_link) else $error("short conditional wrote link");

  property p_count_target;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && !i_compact_valid && i_kind == JUMP_VIA_COUNT && next_taken)
      |=> (o_next_instr_address[1:0] == 2'b00 && o_taken);
  endproperty
  a_count_target: assert property (p_count_target) else $error("count target misaligned");

  property p_cond_fall;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && !i_compact_valid && i_kind == JUMP_LONG_COND && !(ctr_ok && cond_ok))
      |=> (o_next_instr_address == $past(current_instr_address) + 32'h0000_0004 && !o_taken);
  endproperty
  a_cond_fall: assert property (p_cond_fall) else $error("conditional fall-through wrong");

  property p_valid_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_valid |=> o_next_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("next address not presented");
endmodule

// ==== verification/fetch_stage_model.sv ====
// -----------------------------------------
// Fetch stage model
// -----------------------------------------
module fetch_stage_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_next_valid,
  input wire logic [31:0] i_next_instr_address,
  output logic [31:0] o_fetch_address
);
  timeunit 1ns;
  timeprecision 100ps;
  // Fetch pointer follows every redirect; a stale pointer shows a lost answer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fetch_address <= 32'h0;
    end else if (i_next_valid) begin
      o_fetch_address <= i_next_instr_address;
    end
  end
endmodule

// ==== verification/tb.sv ====
module tb import branch_target_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------
  // Signals
  // -----------------------------------------
  logic i_clk, i_rst_n, i_valid, i_compact_valid, i_absolute_flag, i_link_flag, i_short_options_bit;
  logic i_cr_write, i_count_write, o_next_valid, o_taken;
  jump_kind_t i_kind;
  cond_form_t i_compact_form;
  logic [31:0] i_current_instr_address, i_condition_register, i_count_value, fetch_address;
  logic [31:0] o_next_instr_address, o_link_register, o_count_register, o_condition_register;
  logic [23:0] i_long_jump_offset, i_long_displacement;
  logic [7:0] i_short_displacement;
  logic [13:0] i_cond_displacement;
  logic [14:0] i_mid_displacement;
  logic [4:0] i_branch_options, i_condition_index;
  logic [3:0] i_long_options_field, i_long_condition_index;
  logic [1:0] i_short_condition_index;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  branch_target_unit u_dut (.i_clk, .i_rst_n, .i_valid, .i_kind, .i_compact_valid, .i_compact_form,
    .i_current_instr_address, .i_absolute_flag, .i_link_flag, .i_long_jump_offset, .i_long_displacement,
    .i_short_displacement, .i_cond_displacement, .i_mid_displacement, .i_branch_options, .i_condition_index,
    .i_long_options_field, .i_long_condition_index, .i_short_options_bit, .i_short_condition_index,
    .i_cr_write, .i_condition_register, .i_count_write, .i_count_value, .o_next_valid,
    .o_next_instr_address, .o_taken, .o_link_register, .o_count_register, .o_condition_register);

  fetch_stage_model u_fetch (.i_clk, .i_rst_n, .i_next_valid(o_next_valid),
    .i_next_instr_address(o_next_instr_address), .o_fetch_address(fetch_address));

  // Free-running core clock, 5 ns period
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  // -----------------------------------------
  // Checks and drivers
  // -----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("TB: failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: all scenarios fit well inside this many cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end

  // Quiet defaults; every field but i_kind (JUMP_NONE) and i_compact_form (COND_COMPACT), the displacement fields included, starts at zero
  task automatic clear();
    {i_valid, i_compact_valid, i_absolute_flag, i_link_flag, i_short_options_bit} = 5'h0;
    {i_cr_write, i_count_write, i_count_value, i_condition_register} = 66'h0;
    i_kind = JUMP_NONE;
    i_compact_form = COND_COMPACT;
    {i_long_jump_offset, i_long_displacement, i_short_displacement} = 56'h0;
    {i_cond_displacement, i_mid_displacement, i_branch_options, i_condition_index} = 39'h0;
    {i_long_options_field, i_long_condition_index, i_short_condition_index} = 10'h0;
    i_current_instr_address = 32'h0;
  endtask

  // Load count and condition registers through the pipeline ports
  task automatic ld(input logic [31:0] cnt, input logic [31:0] cr);
    {i_count_write, i_cr_write, i_count_value, i_condition_register} = {2'h3, cnt, cr};
    @(negedge i_clk);
    {i_count_write, i_cr_write} = 2'h0;
    chk(o_condition_register, cr);
    chk(o_count_register, cnt);
  endtask

  // One request, answer one cycle later, fetch redirect the cycle after
  task automatic go(input logic [31:0] next_instr_address, input logic tk);
    i_valid = 1'b1;
    @(negedge i_clk);
    i_valid = 1'b0;
    chk({31'h0, o_next_valid}, 32'h1);
    chk(o_next_instr_address, next_instr_address);
    chk({31'h0, o_taken}, {31'h0, tk});
    @(negedge i_clk);
    chk({31'h0, o_next_valid}, 32'h0);
    chk(fetch_address, next_instr_address);
  endtask

  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task automatic t_uncond();
    clear();
    // Enum fields are set on their own; a packed lvalue would need a cast
    i_kind = JUMP_LONG_UNCOND;
    {i_current_instr_address, i_long_jump_offset, i_link_flag} = {32'h1000, 24'hfffffe, 1'h1};
    go(32'h0ff8, 1'b1);
    chk(o_link_register, 32'h1004);
    {i_absolute_flag, i_long_jump_offset, i_link_flag} = {1'b1, 24'h000010, 1'b0};
    go(32'h0040, 1'b1);
    chk(o_link_register, 32'h1004);
    {i_absolute_flag, i_current_instr_address, i_long_jump_offset} = {1'b0, 32'hfffffffc, 24'h000001};
    go(32'h0, 1'b1);
  endtask

  task automatic t_relative();
    clear();
    i_kind = JUMP_LONG_RELATIVE;
    {i_current_instr_address, i_long_displacement, i_link_flag} = {32'h100, 24'h2, 1'h1};
    go(32'h0104, 1'b1);
    chk(o_link_register, 32'h0104);
    {i_current_instr_address, i_long_displacement} = {32'h01000000, 24'h800000};
    go(32'h0, 1'b1);
    i_kind = JUMP_SHORT_RELATIVE;
    {i_current_instr_address, i_short_displacement} = {32'h200, 8'h80};
    go(32'h0100, 1'b1);
    chk(o_link_register, 32'h0202);
  endtask

  task automatic t_long_cond();
    clear();
    ld(32'h1, 32'h20000000);
    i_kind = JUMP_LONG_COND;
    {i_current_instr_address, i_cond_displacement} = {32'h400, 14'h3fff};
    {i_branch_options, i_condition_index} = {5'h02, 5'h02};
    go(32'h0404, 1'b0);
    chk(o_count_register, 32'h0);
    // Zero count wraps to all ones on the next decrement
    go(32'h03fc, 1'b1);
    chk(o_count_register, 32'hffffffff);
    {i_branch_options, i_condition_index} = {5'h06, 5'h03};
    go(32'h0404, 1'b0);
    chk(o_count_register, 32'hffffffff);
    {i_branch_options, i_absolute_flag, i_link_flag, i_cond_displacement} = {5'b00101, 2'b11, 14'h10};
    go(32'h0040, 1'b1);
    chk(o_link_register, 32'h0404);
  endtask

  task automatic t_compact();
    clear();
    ld(32'h2, 32'h00010000);
    i_compact_form = COND_COMPACT;
    {i_compact_valid, i_current_instr_address} = {1'h1, 32'h800};
    {i_mid_displacement, i_long_options_field, i_long_condition_index} = {15'h7ff0, 4'b0001, 4'd14};
    go(32'h07e0, 1'b1);
    chk(o_count_register, 32'h1);
    {i_long_options_field, i_long_condition_index} = {4'b0010, 4'd15};
    go(32'h07e0, 1'b1);
    chk(o_count_register, 32'h1);
    {i_long_condition_index, i_link_flag} = {4'd14, 1'b1};
    go(32'h0804, 1'b0);
    chk(o_link_register, 32'h0804);
  endtask

  task automatic t_short_cond();
    logic [31:0] lr;
    clear();
    ld(32'h5, 32'h10000000);
    lr = o_link_register;
    i_compact_form = COND_SHORT;
    {i_compact_valid, i_current_instr_address, i_link_flag} = {1'h1, 32'h900, 1'h1};
    {i_short_displacement, i_short_condition_index, i_short_options_bit} = {8'h10, 2'd3, 1'b1};
    go(32'h0920, 1'b1);
    i_short_condition_index = 2'd2;
    go(32'h0902, 1'b0);
    chk(o_link_register, lr);
    chk(o_count_register, 32'h5);
  endtask

  task automatic t_count();
    clear();
    ld(32'h12345677, 32'h80000000);
    i_kind = JUMP_VIA_COUNT;
    {i_current_instr_address, i_branch_options} = {32'ha00, 5'h02};
    go(32'h12345674, 1'b1);
    {i_branch_options, i_link_flag} = {5'b00000, 1'b1};
    go(32'h0a04, 1'b0);
    chk(o_link_register, 32'h0a04);
    chk(o_count_register, 32'h12345677);
  endtask

  // -----------------------------------------
  // Run
  // -----------------------------------------
  initial begin
    clear();
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_clk);
    chk(o_next_instr_address | o_link_register | o_count_register, 32'h0);
    // Strobe and taken flag must also come out of reset low
    chk({30'h0, o_next_valid, o_taken}, 32'h0);
    i_rst_n = 1'b1;
    t_uncond();
    t_relative();
    t_long_cond();
    t_compact();
    t_short_cond();
    t_count();
    end_of_test();
  end
endmodule
